// ---- logic/ubde_engine.sv ----
`timescale 1ns/1ps
// How it works
// - Owned status byte is rewritten with the token PID in bits 5..2.
// - Completion writes count low byte; bits 9..8 go into status bits 1..0.
// - IN sends the descriptor count and writes back the bytes sent.
// - OUT uses the count as limit and writes back bytes received.
// - Oversized OUT packet is rejected with NAK, count left unchanged.
// - Byte count is ten bits, low byte plus two status bits.
// - Buffer start address is taken from address bytes, never checked.
// - Four ping-pong modes chosen by the mode field input.
// - Two pointers per endpoint (OUT and IN), all even while module is disabled.
// - Pointer toggles each time a ping-pong transaction completes and ownership clears.
// - Transfer status records whether the last transaction was odd.
// - Pointer reset control forces every pointer to even.
// - Mode 0 and mode 1 descriptor index mapping per endpoint.
// - Mode 2 and mode 3 descriptor index mapping per endpoint.
// - Status byte: own, toggle, check enable, stall, count high bits.
// - Toggle value is ignored unless toggle check is enabled.
// - Thirty-two four-byte descriptors, contents undefined after reset.
// - All sources funnel into one interrupt request flag.
// - Two flag levels; enabled error flags set the error summary flag.
// - Enabled status flags are ORed into the interrupt request.
// - Flags are sticky until cleared; software may also set them.
// - Ownership is cleared when the transaction completes.
// - Enables only gate propagation; flags always set.
// - Error flags set at once when the error is seen.
module ubde_engine
  import ubde_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // Configuration
  input  wire logic               usb_enable,
  input  wire logic [1:0]         ping_pong_mode_field,
  input  wire logic               pointer_reset_control,
  // CPU access to descriptor RAM
  input  wire logic               cpu_we,
  input  wire logic [MEM_AW-1:0]  cpu_addr,
  input  wire logic [7:0]         cpu_wdata,
  output logic [7:0]              cpu_rdata,
  // Transaction request from packet logic
  input  wire logic               req_valid,
  input  wire ubde_req_t          req,
  output logic                    req_ready,
  // Answer to packet logic
  output logic                    ans_valid,
  output ubde_ans_t               ans,
  output ubde_transfer_status_register_t             transfer_status_register,
  // Event sources
  input  wire logic [7:0]         stat_evt,
  input  wire logic [7:0]         err_evt,
  // Flag registers
  input  wire logic [7:0]         status_interrupt_enables,
  input  wire logic [7:0]         error_interrupt_enables,
  input  wire logic               stat_we,
  input  wire logic [7:0]         stat_wdata,
  input  wire logic               err_we,
  input  wire logic [7:0]         err_wdata,
  input  wire logic               irq_clr,
  input  wire logic               irq_set,
  output logic [7:0]              status_flag_register,
  output logic [7:0]              error_flag_register,
  output logic                    usb_interrupt_request_flag
);

  typedef enum logic [1:0] {
    UBDE_IDLE = 2'b00,
    UBDE_EVAL = 2'b01,
    UBDE_DONE = 2'b11
  } ubde_state_t;

  logic [7:0]          mem [BD_NUM*BD_BYTES];
  ubde_state_t         state_reg, state_next;
  ubde_req_t           req_reg;
  logic [4:0]          idx_reg;
  logic                odd_reg;
  logic [EP_NUM-1:0]   ptr_out_reg, ptr_in_reg;
  logic [7:0]          rdata_reg, stat_reg, err_reg;
  logic                irq_reg, ready_reg, ans_v_reg;
  ubde_ans_t           ans_reg;
  ubde_transfer_status_register_t         transfer_status_register_reg;

  // Descriptor lookup for the incoming request
  wire [2:0] ep      = req.ep;
  wire [6:0] ep_w    = {4'h0, ep};
  wire       ep0     = (ep == 3'h0);
  wire       pp_on   = (ping_pong_mode_field == PP_ALL) ||
                       (ping_pong_mode_field == PP_EP0 && ep0 && !req.is_in) ||
                       (ping_pong_mode_field == PP_XEP0 && !ep0);
  wire       ptr_sel = req.is_in ? ptr_in_reg[ep] : ptr_out_reg[ep];
  wire       odd     = pp_on && ptr_sel;
  wire [6:0] in_w    = {6'h00, req.is_in};
  wire [6:0] odd_w   = {6'h00, odd};
  wire [6:0] idx_m0  = (ep_w << 1) + in_w;
  wire [6:0] idx_m1  = ep0 ? (req.is_in ? 7'h02 : odd_w)
                           : (ep_w << 1) + 7'h01 + in_w;
  wire [6:0] idx_m2  = (ep_w << 2) + (in_w << 1) + odd_w;
  wire [6:0] idx_m3  = ep0 ? in_w
                           : (ep_w << 2) - 7'h02 + (in_w << 1) + odd_w;
  wire [6:0] idx_w   = (ping_pong_mode_field == PP_NONE) ? idx_m0 :
                       (ping_pong_mode_field == PP_EP0)  ? idx_m1 :
                       (ping_pong_mode_field == PP_ALL)  ? idx_m2 : idx_m3;

  // Descriptor fields of the captured request
  wire [6:0] base    = {idx_reg, 2'h0};
  wire [7:0] bd_st   = mem[base + {5'h00, BD_STAT}];
  wire [7:0] bd_cnt  = mem[base + {5'h00, BD_CNT}];
  wire [7:0] bd_adl  = mem[base + {5'h00, BD_ADRL}];
  wire [7:0] bd_adh  = mem[base + {5'h00, BD_ADRH}];
  wire [9:0] limit   = {bd_st[ST_BC9:0], bd_cnt};
  wire       owned   = bd_st[ST_OWN];
  wire       stall   = bd_st[ST_STALL];
  wire       tog_bad = bd_st[ST_TOGGLE_CHECK_ENABLE] &&
                       (bd_st[ST_DTS] != req_reg.toggle);
  wire       too_big = !req_reg.is_in && (req_reg.rx_len > limit);
  wire [9:0] xfer    = req_reg.is_in ? limit : req_reg.rx_len;
  wire       in_eval = (state_reg == UBDE_EVAL);
  wire       live    = in_eval && owned && !req_reg.bad && !stall;
  wire       upd     = live && !too_big &&
                       (req_reg.is_in || !tog_bad);
  wire [7:0] st_wb   = {1'b0, bd_st[ST_DTS], req_reg.pid,
                        xfer[9:8]};
  wire [1:0] code_w  = (!in_eval || !owned) ? ANS_NAK :
                       req_reg.bad          ? ANS_NONE :
                       stall                ? ANS_STALL :
                       too_big              ? ANS_NAK : ANS_ACK;

  // Flag funnel
  wire [7:0] err_next = (err_we ? err_wdata : err_reg) | err_evt;
  wire       err_sum  = |(err_reg & error_interrupt_enables);
  wire [7:0] stat_src = stat_evt | {4'h0, upd, 1'b0, err_sum, 1'b0};
  wire [7:0] stat_nxt = (stat_we ? stat_wdata : stat_reg) | stat_src;
  wire       irq_src  = |(stat_reg & status_interrupt_enables);
  wire       irq_next = (irq_clr ? 1'b0 : irq_reg) | irq_src | irq_set;
  wire       ptr_clr  = !usb_enable || pointer_reset_control;
  wire       take     = ready_reg && req_valid;
  wire       ptr_sel_r = ptr_out_reg[req_reg.ep];
  wire       pp_eval  = (ping_pong_mode_field == PP_ALL) ||
                        (ping_pong_mode_field == PP_EP0 && !req_reg.is_in &&
                         req_reg.ep == 3'h0) ||
                        (ping_pong_mode_field == PP_XEP0 &&
                         req_reg.ep != 3'h0);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      UBDE_IDLE: if (take) state_next = UBDE_EVAL;
      UBDE_EVAL: state_next = UBDE_DONE;
      UBDE_DONE: state_next = UBDE_IDLE;
      default:   state_next = UBDE_IDLE;
    endcase
  end

  // Descriptor RAM, no reset: contents undefined after reset
  always_ff @(posedge clk_sys) begin
    if (upd) begin
      mem[base + {5'h00, BD_STAT}] <= st_wb;
      mem[base + {5'h00, BD_CNT}]  <= xfer[7:0];
    end else if (cpu_we) begin
      mem[cpu_addr] <= cpu_wdata;
    end
    rdata_reg <= mem[cpu_addr];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= UBDE_IDLE;
      req_reg   <= '0;
      idx_reg   <= 5'h00;
      odd_reg   <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == UBDE_IDLE);
      if (take) begin
        req_reg <= req;
        idx_reg <= idx_w[4:0];
        odd_reg <= odd;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || ptr_clr) begin
      ptr_out_reg <= '0;
      ptr_in_reg  <= '0;
    end else if (upd) begin
      if (req_reg.is_in) ptr_in_reg[req_reg.ep] <= pp_eval ^
                           ptr_in_reg[req_reg.ep];
      else ptr_out_reg[req_reg.ep] <= pp_eval ^
                           ptr_out_reg[req_reg.ep];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ans_v_reg <= 1'b0;
      ans_reg   <= '0;
      transfer_status_register_reg <= '0;
    end else begin
      ans_v_reg <= in_eval;
      if (in_eval) begin
        ans_reg.code  <= code_w;
        ans_reg.count <= xfer;
        ans_reg.addr  <= {bd_adh, bd_adl};
      end
      if (upd) transfer_status_register_reg <= '{req_reg.ep, req_reg.is_in, odd_reg};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_reg <= FLAGS_RST;
      err_reg  <= FLAGS_RST;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_nxt;
      err_reg  <= err_next;
      irq_reg  <= irq_next;
    end
  end

  assign cpu_rdata                  = rdata_reg;
  assign req_ready                  = ready_reg;
  assign ans_valid                  = ans_v_reg;
  assign ans                        = ans_reg;
  assign transfer_status_register   = transfer_status_register_reg;
  assign status_flag_register       = stat_reg;
  assign error_flag_register        = err_reg;
  assign usb_interrupt_request_flag = irq_reg;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_upd;
    upd ##0 !cpu_we;
  endsequence
  sequence s_nak_big;
    in_eval && owned && !req_reg.bad && !stall && too_big;
  endsequence

  own_clear_a: assert property (s_upd |=> !bd_st[ST_OWN] &&
    bd_st[ST_PID_HI:ST_PID_LO] == $past(req_reg.pid))
    else $error("ownership or pid not written back");
  count_wb_a: assert property (upd |=>
    {bd_st[ST_BC9:0], bd_cnt} == $past(xfer))
    else $error("count write-back wrong");
  nak_limit_a: assert property (s_nak_big |=> ans_valid &&
    ans.code == ANS_NAK && $stable(bd_cnt))
    else $error("oversized packet not refused");
  ptr_rst_a: assert property (pointer_reset_control |=>
    ptr_out_reg == '0 && ptr_in_reg == '0)
    else $error("pointer reset ignored");
  ptr_tog_a: assert property (upd && pp_eval && !ptr_clr &&
    !req_reg.is_in |=> ptr_out_reg[req_reg.ep] != $past(ptr_sel_r))
    else $error("pointer did not toggle");
  even_odd_indicator_a: assert property (upd |=>
    transfer_status_register.odd == $past(odd_reg))
    else $error("even odd indicator wrong");
  err_sum_a: assert property (|(err_reg & error_interrupt_enables)
    |=> status_flag_register[FL_ERR])
    else $error("error summary not set");
  irq_a: assert property (irq_src |=> usb_interrupt_request_flag)
    else $error("interrupt request not raised");
  sticky_a: assert property (stat_reg[FL_TRN] && !stat_we
    |=> stat_reg[FL_TRN])
    else $error("status flag lost");

endmodule // ubde_engine

// ---- common/ubde_pkg.sv ----
package ubde_pkg;
  localparam int BD_NUM    = 32;
  localparam int BD_BYTES  = 4;
  localparam int MEM_AW    = 7;
  localparam int EP_NUM    = 8;
  // Status byte fields
  localparam int ST_OWN    = 7;
  localparam int ST_DTS    = 6;
  localparam int ST_PID_HI = 5;
  localparam int ST_PID_LO = 2;
  localparam int ST_TOGGLE_CHECK_ENABLE  = 3;
  localparam int ST_STALL  = 2;
  localparam int ST_BC9    = 1;
  // Byte slots inside one descriptor
  localparam logic [1:0] BD_STAT = 2'h0;
  localparam logic [1:0] BD_CNT  = 2'h1;
  localparam logic [1:0] BD_ADRL = 2'h2;
  localparam logic [1:0] BD_ADRH = 2'h3;
  // Ping-pong modes
  localparam logic [1:0] PP_NONE = 2'h0;
  localparam logic [1:0] PP_EP0  = 2'h1;
  localparam logic [1:0] PP_ALL  = 2'h2;
  localparam logic [1:0] PP_XEP0 = 2'h3;
  // Handshake answers
  localparam logic [1:0] ANS_NONE  = 2'h0;
  localparam logic [1:0] ANS_ACK   = 2'h1;
  localparam logic [1:0] ANS_NAK   = 2'h2;
  localparam logic [1:0] ANS_STALL = 2'h3;
  // Status flag positions
  localparam int FL_ERR    = 1;
  localparam int FL_TRN    = 3;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  typedef struct packed {
    logic [2:0] ep;
    logic       is_in;
    logic [3:0] pid;
    logic       toggle;
    logic [9:0] rx_len;
    logic       bad;
  } ubde_req_t;

  typedef struct packed {
    logic [1:0]  code;
    logic [9:0]  count;
    logic [15:0] addr;
  } ubde_ans_t;

  typedef struct packed {
    logic [2:0] ep;
    logic       is_in;
    logic       odd;
  } ubde_transfer_status_register_t;
endpackage

// ---- testbench/ubde_host.sv ----
`timescale 1ns/1ps
module ubde_host
  import ubde_pkg::*;
(
  // Clock
  input  wire logic      clk_sys,
  // Request
  output logic           req_valid,
  output ubde_req_t      req,
  input  wire logic      req_ready,
  // Answer
  input  wire logic      ans_valid,
  input  wire ubde_ans_t ans
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // Holds the request until taken, then shows a changed value
  task automatic xfer(input ubde_req_t r, output ubde_ans_t a,
                      output bit ok, output int lat);
    ok = 1'b0;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req = r;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_sys);
      if (req_ready === 1'b1) ok = 1'b1;
    end
    #1;
    req_valid = 1'b0;
    req = ~r;
    for (lat = 1; lat <= 4; lat++) begin
      @(posedge clk_sys);
      #1;
      if (ans_valid === 1'b1) break;
    end
    a = ans;
  endtask
endmodule // ubde_host

// ---- testbench/usb_buffer_descriptor_engine_tb.sv ----
`timescale 1ns/1ps
module usb_buffer_descriptor_engine_tb;
  import ubde_pkg::*;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              usb_enable = 1'b1;
  logic [1:0]        ping_pong_mode_field = PP_NONE;
  logic              pointer_reset_control = 1'b0;
  logic              cpu_we = 1'b0;
  logic [MEM_AW-1:0] cpu_addr = '0;
  logic [7:0]        cpu_wdata = '0, cpu_rdata;
  logic              req_valid, req_ready, ans_valid;
  ubde_req_t         req;
  ubde_ans_t         ans;
  ubde_transfer_status_register_t       transfer_status_register;
  logic [7:0]        stat_evt = '0, err_evt = '0;
  logic [7:0]        status_interrupt_enables = '0;
  logic [7:0]        error_interrupt_enables = '0;
  logic              stat_we = 1'b0, err_we = 1'b0;
  logic [7:0]        stat_wdata = '0, err_wdata = '0;
  logic              irq_clr = 1'b0, irq_set = 1'b0;
  logic [7:0]        status_flag_register, error_flag_register;
  logic              usb_interrupt_request_flag;
  int                errors = 0, checks = 0;

  always #4 clk_sys = ~clk_sys;

  ubde_engine i_ubde_engine (.clk_sys, .sys_rst, .usb_enable,
    .ping_pong_mode_field, .pointer_reset_control, .cpu_we, .cpu_addr,
    .cpu_wdata, .cpu_rdata, .req_valid, .req, .req_ready, .ans_valid,
    .ans, .transfer_status_register, .stat_evt, .err_evt,
    .status_interrupt_enables, .error_interrupt_enables, .stat_we,
    .stat_wdata, .err_we, .err_wdata, .irq_clr, .irq_set,
    .status_flag_register, .error_flag_register,
    .usb_interrupt_request_flag);
  ubde_host i_ubde_host (.clk_sys, .req_valid, .req, .req_ready,
    .ans_valid, .ans);

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [4:0] i, logic [1:0] s, logic [7:0] d);
    tick();
    cpu_we = 1'b1;
    cpu_addr = {i, s};
    cpu_wdata = d;
    tick();
    cpu_we = 1'b0;
  endtask
  task automatic rd(logic [4:0] i, logic [1:0] s, output logic [7:0] d);
    tick();
    cpu_addr = {i, s};
    tick();
    d = cpu_rdata;
  endtask
  // Status byte goes last so ownership follows the other bytes
  task automatic arm(logic [4:0] i, logic [7:0] cnt, logic [7:0] st);
    wr(i, BD_CNT, cnt);
    wr(i, BD_ADRL, {3'h0, i});
    wr(i, BD_ADRH, 8'hA5);
    wr(i, BD_STAT, st);
  endtask
  task automatic run(logic [2:0] ep, logic in, logic [9:0] rx,
                     output ubde_ans_t a);
    bit ok;
    int lat;
    i_ubde_host.xfer('{ep, in, in ? 4'h9 : 4'h1, 1'b0, rx, 1'b0},
                     a, ok, lat);
    chk("taken", ok, 1'b1);
    if (!ok) end_sim();
    chk("latency", lat, 1);
  endtask
  task automatic go(logic in, logic [4:0] i, logic odd);
    ubde_ans_t a;
    arm(i, 8'h40, 8'h80);
    run(3'd1, in, 10'h001, a);
    chk("bd index", a.addr, {8'hA5, 3'h0, i});
    chk("odd", transfer_status_register.odd, odd);
  endtask
  task automatic prst();
    pointer_reset_control = 1'b1;
    tick();
    pointer_reset_control = 1'b0;
  endtask

  task automatic t_xfer();
    ubde_ans_t a;
    logic [7:0] d;
    arm(5'd2, 8'h40, 8'h80);
    run(3'd1, 1'b0, 10'h005, a);
    chk("out code", a.code, ANS_ACK);
    chk("out count", a.count, 10'h005);
    chk("out addr", a.addr, 16'hA502);
    chk("out transfer_status_register", transfer_status_register, 5'b00100);
    chk("trn flag", status_flag_register[FL_TRN], 1'b1);
    rd(5'd2, BD_STAT, d);
    chk("out stat", d & 8'hBF, 8'h04);
    rd(5'd2, BD_CNT, d);
    chk("out cnt", d, 8'h05);
    arm(5'd2, 8'h03, 8'h80);
    run(3'd1, 1'b0, 10'h005, a);
    chk("big code", a.code, ANS_NAK);
    rd(5'd2, BD_CNT, d);
    chk("big cnt", d, 8'h03);
    arm(5'd3, 8'h05, 8'h81);
    run(3'd1, 1'b1, 10'h000, a);
    chk("in count", a.count, 10'h105);
    rd(5'd3, BD_STAT, d);
    chk("in stat", d & 8'hBF, 8'h25);
    $display("t_xfer done");
  endtask

  task automatic t_map();
    logic [4:0] ix [8] = '{5'd2, 5'd3, 5'd3, 5'd4, 5'd4, 5'd6, 5'd2, 5'd4};
    for (int m = 0; m < 8; m++) begin
      ping_pong_mode_field = m[2:1];
      prst();
      go(m[0], ix[m], 1'b0);
    end
    prst();
    go(1'b0, 5'd2, 1'b0);
    go(1'b0, 5'd3, 1'b1);
    go(1'b0, 5'd2, 1'b0);
    prst();
    go(1'b0, 5'd2, 1'b0);
    usb_enable = 1'b0;
    tick();
    usb_enable = 1'b1;
    go(1'b0, 5'd2, 1'b0);
    $display("t_map done");
  endtask

  task automatic t_refuse();
    ubde_ans_t a;
    logic [7:0] d;
    ping_pong_mode_field = PP_NONE;
    arm(5'd2, 8'h40, 8'h84);
    run(3'd1, 1'b0, 10'h001, a);
    chk("stall code", a.code, ANS_STALL);
    arm(5'd2, 8'h40, 8'h00);
    run(3'd1, 1'b0, 10'h001, a);
    chk("cpu owned", a.code, ANS_NAK);
    arm(5'd2, 8'h40, 8'hC8);
    run(3'd1, 1'b0, 10'h001, a);
    chk("tog code", a.code, ANS_ACK);
    rd(5'd2, BD_STAT, d);
    chk("tog kept", d, 8'hC8);
    arm(5'd2, 8'h40, 8'hC0);
    run(3'd1, 1'b0, 10'h001, a);
    rd(5'd2, BD_STAT, d);
    chk("tog ignored", d, 8'h44);
    $display("t_refuse done");
  endtask

  task automatic t_flags();
    int n;
    err_evt = 8'h04;
    tick();
    err_evt = 8'h00;
    tick();
    chk("err flag", error_flag_register, 8'h04);
    chk("summary off", status_flag_register[FL_ERR], 1'b0);
    error_interrupt_enables = 8'h04;
    tick(2);
    chk("summary on", status_flag_register[FL_ERR], 1'b1);
    chk("irq gated", usb_interrupt_request_flag, 1'b0);
    status_interrupt_enables = 8'h02;
    for (n = 0; n < 5 && usb_interrupt_request_flag !== 1'b1; n++) tick();
    chk("irq", usb_interrupt_request_flag, 1'b1);
    err_we = 1'b1;
    tick();
    err_we = 1'b0;
    stat_we = 1'b1;
    tick();
    stat_we = 1'b0;
    irq_clr = 1'b1;
    tick();
    irq_clr = 1'b0;
    tick(2);
    chk("cleared", {status_flag_register, usb_interrupt_request_flag},
        9'h000);
    stat_we = 1'b1;
    stat_wdata = 8'h01;
    tick();
    stat_we = 1'b0;
    tick(2);
    chk("soft set", status_flag_register, 8'h01);
    $display("t_flags done");
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    tick(4);
    sys_rst = 1'b0;
    tick(2);
    chk("flags reset", status_flag_register, FLAGS_RST);
    t_xfer();
    t_map();
    t_refuse();
    stat_we = 1'b1;
    tick();
    stat_we = 1'b0;
    t_flags();
    end_sim();
  end
endmodule // usb_buffer_descriptor_engine_tb
